// ===== hdl/cell_extreme_aux_fault_status.sv
// Purpose: Extreme-cell locator and auxiliary fault status registers
// Assumes: Avalon-MM slave, byte address, one wait cycle per access
// Notes:   Cell data sampled at the acquisition-done pulse of a scan acquisition
// Contract
// - Report index of highest enabled cell
// - Report index of lowest enabled cell
// - Enabled cells only, arith or filtered data
// - Only scan acquisitions update extreme indexes
// - Ties report the lowest cell index
// - Search limited to selected polarity set
// - No matching cell reports index Fh
// - Aux pin above supply sets protection flag
// - Protection fault opens the pin switch
// - Flag clears on clean retry or deconfigure
// - Any config write counts as retry
// - Read-only six-bit cold flags, reset zero
// - Cold flag set above threshold, cleared next
`timescale 1ns/1ps
`include "cell_extreme_cfg.svh"
module cell_extreme_aux_fault_status (
    input  wire logic                             core_clk_in,
    input  wire logic                             rst_n_in,
    // Avalon-MM slave
    input  wire logic [7:0]                       avs_address_in,
    input  wire logic                             avs_read_in,
    input  wire logic                             avs_write_in,
    input  wire logic [31:0]                      avs_writedata_in,
    input  wire logic [3:0]                       avs_byteenable_in,
    output logic [31:0]                           avs_readdata_out,
    output logic                                  avs_waitrequest_out,
    // Measurement engine, same clock
    input  wire logic                             acq_done_in,
    input  wire logic                             acq_scan_in,
    input  wire logic [`NUM_CELLS*`CELL_VALUE_W-1:0] arith_result_path_in,
    input  wire logic [`NUM_CELLS*`CELL_VALUE_W-1:0] recursive_filter_path_in,
    input  wire logic [`NUM_AUX-1:0]              aux_cold_compare_in,
    // Analog protection comparators, asynchronous
    input  wire logic [`NUM_AUX-1:0]              aux_over_supply_in,
    // Pin switch control, high opens the switch
    output logic [`NUM_AUX-1:0]                   aux_switch_open_out
);
    // Software registers
    logic                            filtered_read_select;
    logic                            extreme_polarity_select;
    cell_extreme_pkg::cell_mask_t    cell_measure_enable;
    cell_extreme_pkg::cell_mask_t    cell_polarity;
    cell_extreme_pkg::aux_mask_t     aux_pin_config;
    cell_extreme_pkg::aux_mask_t     aux_cold_alert_enable;
    // Status
    cell_extreme_pkg::cell_index_t   highest_cell_index;
    cell_extreme_pkg::cell_index_t   lowest_cell_index;
    cell_extreme_pkg::aux_mask_t     aux_protect_fault_flags;
    cell_extreme_pkg::aux_mask_t     aux_cold_fault_flags;
    cell_extreme_pkg::aux_mask_t     switch_open;
    // Snapshot of one scan
    cell_extreme_pkg::cell_value_t   snap_value [`NUM_CELLS];
    cell_extreme_pkg::cell_mask_t    snap_member;
    logic                            snap_signed;
    // Bus
    logic                            bus_ack;
    logic [31:0]                     read_word;
    // Protection input synchroniser
    cell_extreme_pkg::aux_mask_t     prot_sync1;
    cell_extreme_pkg::aux_mask_t     prot_sync2;
    cell_extreme_pkg::aux_mask_t     prot_sync3;
    cell_extreme_pkg::aux_mask_t     prot_level;

    wire logic                       bus_req;
    wire logic                       wr_take;
    wire logic                       rd_load;
    wire logic [5:0]                 reg_index;
    wire logic                       wr_low;
    wire logic                       wr_high;
    wire logic                       wr_ctrl;
    wire logic                       wr_enable;
    wire logic                       wr_polarity;
    wire logic                       wr_pin_config;
    wire logic                       wr_cold_enable;
    wire logic                       scan_start;
    wire cell_extreme_pkg::cell_mask_t  scan_member;
    wire cell_extreme_pkg::aux_mask_t   next_pin_config;
    wire cell_extreme_pkg::aux_mask_t   prot_set;
    wire cell_extreme_pkg::aux_mask_t   prot_clear;
    wire cell_extreme_pkg::aux_mask_t   next_prot_flags;
    wire cell_extreme_pkg::aux_mask_t   next_switch_open;
    wire cell_extreme_pkg::aux_mask_t   next_cold_flags;
    wire logic [`NUM_CELLS*`CELL_VALUE_W-1:0] picked_data;
    wire logic [3:0]                 probe_slot;
    wire logic [3:0]                 safe_slot;

    extreme_search_if srch ();

    extreme_finder u_finder (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .srch        (srch.finder)
    );

    // Avalon handshake, one wait state on every access
    assign bus_req   = (avs_read_in || avs_write_in) && !bus_ack;
    assign wr_take   = avs_write_in && bus_ack;
    assign rd_load   = avs_read_in && !bus_ack;
    assign reg_index = avs_address_in[7:2];
    assign wr_low    = wr_take && avs_byteenable_in[0];
    assign wr_high   = wr_take && avs_byteenable_in[1];
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !bus_ack;

    assign wr_ctrl        = wr_low && (reg_index == `IDX_EXTREME_CTRL);
    assign wr_enable      = wr_take && (reg_index == `IDX_CELL_ENABLE);
    assign wr_polarity    = wr_take && (reg_index == `IDX_CELL_POLARITY);
    assign wr_pin_config  = wr_low && (reg_index == `IDX_AUX_PIN_CONFIG);
    assign wr_cold_enable = wr_low && (reg_index == `IDX_AUX_COLD_ENABLE);

    // Read mux, status registers ignore writes, unused bits zero
    always_comb begin
        read_word = 32'h0000_0000;
        unique case (reg_index)
            `IDX_EXTREME_CELL: begin
                read_word[`HIGHEST_LSB +: 4] = highest_cell_index;
                read_word[`LOWEST_LSB +: 4]  = lowest_cell_index;
            end
            `IDX_AUX_PROTECT: begin
                read_word[5:0] = aux_protect_fault_flags;
            end
            `IDX_AUX_COLD: begin
                read_word[5:0] = aux_cold_fault_flags;
            end
            `IDX_EXTREME_CTRL: begin
                read_word[`CTRL_FILT_BIT] = filtered_read_select;
                read_word[`CTRL_POL_BIT]  = extreme_polarity_select;
            end
            `IDX_CELL_ENABLE: begin
                read_word[13:0] = cell_measure_enable;
            end
            `IDX_CELL_POLARITY: begin
                read_word[13:0] = cell_polarity;
            end
            `IDX_AUX_PIN_CONFIG: begin
                read_word[5:0] = aux_pin_config;
            end
            `IDX_AUX_COLD_ENABLE: begin
                read_word[5:0] = aux_cold_alert_enable;
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_ack          <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            bus_ack <= bus_req;
            if (rd_load) begin
                avs_readdata_out <= read_word;
            end
        end
    end

    // Configuration registers, byte lane 0 for bits 7:0, lane 1 above
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            filtered_read_select    <= 1'b0;
            extreme_polarity_select <= 1'b0;
            cell_measure_enable     <= `CELL_MASK_RESET;
            cell_polarity           <= `CELL_MASK_RESET;
            aux_pin_config          <= `AUX_MASK_RESET;
            aux_cold_alert_enable   <= `AUX_MASK_RESET;
        end else begin
            if (wr_ctrl) begin
                filtered_read_select    <= avs_writedata_in[`CTRL_FILT_BIT];
                extreme_polarity_select <= avs_writedata_in[`CTRL_POL_BIT];
            end
            if (wr_enable && wr_low) begin
                cell_measure_enable[7:0] <= avs_writedata_in[7:0];
            end
            if (wr_enable && wr_high) begin
                cell_measure_enable[13:8] <= avs_writedata_in[13:8];
            end
            if (wr_polarity && wr_low) begin
                cell_polarity[7:0] <= avs_writedata_in[7:0];
            end
            if (wr_polarity && wr_high) begin
                cell_polarity[13:8] <= avs_writedata_in[13:8];
            end
            if (wr_pin_config) begin
                aux_pin_config <= next_pin_config;
            end
            if (wr_cold_enable) begin
                aux_cold_alert_enable <= avs_writedata_in[5:0];
            end
        end
    end

    // Scan snapshot and search start
    assign scan_start  = acq_done_in && acq_scan_in;
    assign picked_data = filtered_read_select ? recursive_filter_path_in
                                              : arith_result_path_in;
    // Member: enabled and of the selected polarity
    assign scan_member = cell_measure_enable &
                         ~(cell_polarity ^
                           {`NUM_CELLS{extreme_polarity_select}});

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            snap_member <= `CELL_MASK_RESET;
            snap_signed <= 1'b0;
            for (int i = 0; i < `NUM_CELLS; i++) begin
                snap_value[i] <= '0;
            end
        end else if (scan_start) begin
            snap_member <= scan_member;
            snap_signed <= extreme_polarity_select;
            for (int i = 0; i < `NUM_CELLS; i++) begin
                snap_value[i] <= picked_data[i*`CELL_VALUE_W +: `CELL_VALUE_W];
            end
        end
    end

    // Finder probes cell n at slot n-1; parked index reads slot 0
    assign probe_slot        = srch.probe_index - 4'h1;
    assign safe_slot         = (probe_slot < 4'(`NUM_CELLS)) ? probe_slot
                                                           : 4'h0;
    assign srch.start        = scan_start;
    assign srch.signed_cmp   = snap_signed;
    assign srch.probe_value  = snap_value[safe_slot];
    assign srch.probe_member = snap_member[safe_slot];

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            highest_cell_index <= 4'(`EXTREME_RESET >> `HIGHEST_LSB);
            lowest_cell_index  <= 4'(`EXTREME_RESET >> `LOWEST_LSB);
        end else if (srch.done && !scan_start) begin
            highest_cell_index <= srch.highest;
            lowest_cell_index  <= srch.lowest;
        end
    end

    // Protection comparator: three flops, level once two and three agree
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prot_sync1 <= `FLAGS_RESET;
            prot_sync2 <= `FLAGS_RESET;
            prot_sync3 <= `FLAGS_RESET;
            prot_level <= `FLAGS_RESET;
        end else begin
            prot_sync1 <= aux_over_supply_in;
            prot_sync2 <= prot_sync1;
            prot_sync3 <= prot_sync2;
            for (int i = 0; i < `NUM_AUX; i++) begin
                if (prot_sync2[i] == prot_sync3[i]) begin
                    prot_level[i] <= prot_sync3[i];
                end
            end
        end
    end

    assign next_pin_config = avs_writedata_in[5:0];
    // Evaluated only on aux pins whose switch is closed
    assign prot_set   = prot_level & aux_pin_config & ~switch_open;
    // Any config write retries, even with an unchanged value
    assign prot_clear = {`NUM_AUX{wr_pin_config}};
    // Set wins over the retry clear
    assign next_prot_flags = (aux_protect_fault_flags & ~prot_clear) |
                             prot_set;
    // Open on fault; retry recloses on aux pins; non-aux pins kept open
    assign next_switch_open = wr_pin_config ? ~next_pin_config
                                            : (switch_open | prot_set);

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aux_protect_fault_flags <= `FLAGS_RESET;
            switch_open             <= ~`AUX_MASK_RESET;
        end else begin
            aux_protect_fault_flags <= next_prot_flags;
            switch_open             <= next_switch_open;
        end
    end

    assign aux_switch_open_out = switch_open;

    // Cold flags follow each acquisition; faulted pins are invalid
    assign next_cold_flags = aux_cold_compare_in & aux_cold_alert_enable &
                             aux_pin_config & ~aux_protect_fault_flags &
                             ~switch_open;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aux_cold_fault_flags <= `FLAGS_RESET;
        end else if (acq_done_in) begin
            aux_cold_fault_flags <= next_cold_flags;
        end
    end
endmodule : cell_extreme_aux_fault_status

// ===== hdl/extreme_finder.sv
// Purpose: Walks cells 1 to 14, keeps highest and lowest member
// Assumes: Start may restart a running search
// Notes:   Strict compare keeps the lowest index on ties
`timescale 1ns/1ps
`include "cell_extreme_cfg.svh"
module extreme_finder (
    input  wire logic           core_clk_in,
    input  wire logic           rst_n_in,
    extreme_search_if.finder    srch
);
    cell_extreme_pkg::finder_state_e state;
    cell_extreme_pkg::cell_index_t   index;
    cell_extreme_pkg::cell_index_t   best_hi;
    cell_extreme_pkg::cell_index_t   best_lo;
    cell_extreme_pkg::cell_value_t   hi_value;
    cell_extreme_pkg::cell_value_t   lo_value;
    logic                            found;
    wire logic                       above;
    wire logic                       below;
    wire logic                       take;
    wire logic                       last;

    assign above = srch.signed_cmp ? ($signed(srch.probe_value) >
                                      $signed(hi_value))
                                   : (srch.probe_value > hi_value);
    assign below = srch.signed_cmp ? ($signed(srch.probe_value) <
                                      $signed(lo_value))
                                   : (srch.probe_value < lo_value);
    assign take  = (state == cell_extreme_pkg::FIND_SEARCH) &&
                   srch.probe_member;
    assign last  = (index == `LAST_CELL_INDEX);
    assign srch.probe_index = index;
    assign srch.done        = (state == cell_extreme_pkg::FIND_DONE);
    // No member found reports the no-result code
    assign srch.highest = found ? best_hi : `NO_RESULT_INDEX;
    assign srch.lowest  = found ? best_lo : `NO_RESULT_INDEX;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= cell_extreme_pkg::FIND_IDLE;
            index <= `FIRST_CELL_INDEX;
        end else if (srch.start) begin
            state <= cell_extreme_pkg::FIND_SEARCH;
            index <= `FIRST_CELL_INDEX;
        end else begin
            unique case (state)
                cell_extreme_pkg::FIND_IDLE: begin
                    state <= cell_extreme_pkg::FIND_IDLE;
                end
                cell_extreme_pkg::FIND_SEARCH: begin
                    if (last) begin
                        state <= cell_extreme_pkg::FIND_DONE;
                    end
                    index <= index + 4'h1;
                end
                cell_extreme_pkg::FIND_DONE: begin
                    state <= cell_extreme_pkg::FIND_IDLE;
                end
                default: begin
                    state <= cell_extreme_pkg::FIND_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            found    <= 1'b0;
            best_hi  <= `FIRST_CELL_INDEX;
            best_lo  <= `FIRST_CELL_INDEX;
            hi_value <= '0;
            lo_value <= '0;
        end else if (srch.start) begin
            found <= 1'b0;
        end else if (take) begin
            found <= 1'b1;
            if (!found || above) begin
                best_hi  <= index;
                hi_value <= srch.probe_value;
            end
            if (!found || below) begin
                best_lo  <= index;
                lo_value <= srch.probe_value;
            end
        end
    end
endmodule : extreme_finder

// ===== inc/cell_extreme_cfg.svh
// Purpose: Offsets, field positions, reset values and counts
// Assumes: Register index times four gives the byte address
// Notes:   Definitions only
`ifndef CELL_EXTREME_CFG_SVH
`define CELL_EXTREME_CFG_SVH

`define NUM_CELLS            14
`define NUM_AUX              6
`define CELL_VALUE_W         16
`define CELL_INDEX_W         4
`define NO_RESULT_INDEX      4'hf
`define FIRST_CELL_INDEX     4'h1
`define LAST_CELL_INDEX      4'he

// Register indexes, byte address is index * 4
`define IDX_EXTREME_CELL     6'h0a
`define IDX_AUX_PROTECT      6'h0b
`define IDX_AUX_COLD         6'h0c
`define IDX_EXTREME_CTRL     6'h10
`define IDX_CELL_ENABLE      6'h11
`define IDX_CELL_POLARITY    6'h12
`define IDX_AUX_PIN_CONFIG   6'h13
`define IDX_AUX_COLD_ENABLE  6'h14

// Field positions
`define HIGHEST_LSB          8
`define LOWEST_LSB           0
`define CTRL_FILT_BIT        0
`define CTRL_POL_BIT         1

// Reset values
`define EXTREME_RESET        16'h0000
`define FLAGS_RESET          6'h00
`define CELL_MASK_RESET      14'h0000
`define AUX_MASK_RESET       6'h00

`endif

// ===== inc/cell_extreme_pkg.sv
// Purpose: Types shared by the extreme-cell status logic
// Assumes: Widths come from the cfg header
// Notes:   Types only
`include "cell_extreme_cfg.svh"
package cell_extreme_pkg;
    typedef logic [`CELL_VALUE_W-1:0] cell_value_t;
    typedef logic [`CELL_INDEX_W-1:0] cell_index_t;
    typedef logic [`NUM_CELLS-1:0]    cell_mask_t;
    typedef logic [`NUM_AUX-1:0]      aux_mask_t;

    // Gray order along idle, search, done
    typedef enum logic [1:0] {
        FIND_IDLE   = 2'b00,
        FIND_SEARCH = 2'b01,
        FIND_DONE   = 2'b11
    } finder_state_e;
endpackage : cell_extreme_pkg

// ===== inc/extreme_search_if.sv
// Purpose: Carries one extreme search between control and finder
// Assumes: Values stay stable while a search is running
// Notes:   Finder walks cell indexes, control returns the value
`timescale 1ns/1ps
interface extreme_search_if;
    logic                         start;
    logic                         signed_cmp;
    cell_extreme_pkg::cell_index_t  probe_index;
    cell_extreme_pkg::cell_value_t  probe_value;
    logic                         probe_member;
    logic                         done;
    cell_extreme_pkg::cell_index_t  highest;
    cell_extreme_pkg::cell_index_t  lowest;

    modport control (
        output start,
        output signed_cmp,
        input  probe_index,
        output probe_value,
        output probe_member,
        input  done,
        input  highest,
        input  lowest
    );
    modport finder (
        input  start,
        input  signed_cmp,
        output probe_index,
        input  probe_value,
        input  probe_member,
        output done,
        output highest,
        output lowest
    );
endinterface : extreme_search_if

// ===== test/cell_extreme_aux_fault_status_monitor.sv
// Purpose: Port-level assertions for the extreme-cell status block
// Assumes: One wait cycle per register access
// Notes:   Bound to the top module
`timescale 1ns/1ps
`include "cell_extreme_cfg.svh"
module cell_extreme_aux_fault_status_monitor (
    input  wire logic                core_clk_in,
    input  wire logic                rst_n_in,
    input  wire logic [7:0]          avs_address_in,
    input  wire logic                avs_read_in,
    input  wire logic                avs_write_in,
    input  wire logic [31:0]         avs_readdata_out,
    input  wire logic                avs_waitrequest_out,
    input  wire logic [`NUM_AUX-1:0] aux_switch_open_out
);
    default clocking mon_cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic [5:0] idx     = avs_address_in[7:2];
    wire logic       rd_take = avs_read_in && avs_waitrequest_out;
    wire logic       cfg_wr  = avs_write_in && !avs_waitrequest_out
                               && idx == 6'h13;
    sequence s_req_start; $rose(avs_read_in || avs_write_in); endsequence
    sequence s_answer; avs_waitrequest_out ##1 !avs_waitrequest_out; endsequence

    a_wait_once: assert property (s_req_start |-> s_answer)
        else $error("request not answered after one wait cycle");
    a_idle_no_wait: assert property (!(avs_read_in || avs_write_in)
        |-> !avs_waitrequest_out) else $error("wait without request");
    a_upper_zero: assert property (avs_readdata_out[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_data_held: assert property (!$past(rd_take)
        |-> $stable(avs_readdata_out)) else $error("read data moved");
    a_extreme_pad: assert property ($past(rd_take && idx == 6'h0a)
        |-> (avs_readdata_out & 32'h0000f0f0) == 32'h0) else $error("pad set");
    a_flag_width: assert property ($past(rd_take && (idx == 6'h0b ||
        idx == 6'h0c)) |-> avs_readdata_out[15:6] == 10'h000)
        else $error("flag word too wide");
    a_unmapped_zero: assert property ($past(rd_take && idx > 6'h14)
        |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
    a_close_by_write: assert property (|($past(aux_switch_open_out)
        & ~aux_switch_open_out) |-> $past(cfg_wr))
        else $error("switch closed without config write");
endmodule : cell_extreme_aux_fault_status_monitor

bind cell_extreme_aux_fault_status cell_extreme_aux_fault_status_monitor
    cell_extreme_aux_fault_status_monitor_inst (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .aux_switch_open_out(aux_switch_open_out));

// ===== test/cell_extreme_aux_fault_status_tb_top.sv
// Purpose: Self-checking bench for extreme-cell and aux fault status
// Assumes: Search result lands within 20 cycles of the scan pulse
// Notes:   Model recomputes extreme and cold results from the driven stimulus
`timescale 1ns/1ps
module cell_extreme_aux_fault_status_tb_top;
    logic         core_clk_in = 1'b0;
    logic         rst_n_in    = 1'b0;
    logic [7:0]   address     = 8'h00;
    logic         read        = 1'b0;
    logic         write       = 1'b0;
    logic [31:0]  wdata       = 32'h0;
    logic         acq_done    = 1'b0;
    logic         acq_scan    = 1'b0;
    logic [223:0] arith       = '0;
    logic [223:0] filt        = '0;
    logic [5:0]   cold_cmp    = 6'h00;
    logic [5:0]   over        = 6'h00;
    logic [31:0]  rdata, q;
    logic [5:0]   sw_open;
    logic         waitreq;
    logic [15:0]  ext;
    logic [13:0]  en, pol;
    int           errors = 0;
    int           n_tests = 0;
    int           i;

    cell_extreme_aux_fault_status cell_extreme_aux_fault_status_inst (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .avs_address_in(address), .avs_read_in(read), .avs_write_in(write),
        .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .acq_done_in(acq_done), .acq_scan_in(acq_scan),
        .arith_result_path_in(arith), .recursive_filter_path_in(filt),
        .aux_cold_compare_in(cold_cmp), .aux_over_supply_in(over),
        .aux_switch_open_out(sw_open));

    always #50 core_clk_in = ~core_clk_in;

    task automatic finish_test;
        if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Master holds the request until waitrequest is seen low
    task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge core_clk_in);
        read <= !wr;
        write <= wr;
        address <= a;
        wdata <= d;
        do begin
            @(posedge core_clk_in);
            k++;
        end while (waitreq !== 1'b0 && k < 20);
        q = rdata;
        if (waitreq !== 1'b0) begin
            errors++;
            finish_test();
        end
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic acq(input bit s);
        @(posedge core_clk_in);
        acq_done <= 1'b1;
        acq_scan <= s;
        @(posedge core_clk_in);
        acq_done <= 1'b0;
        repeat (20) @(posedge core_clk_in);
    endtask : acq

    task automatic sw(input logic [5:0] exp);
        @(negedge core_clk_in);
        chk(32'(sw_open), 32'(exp));
        @(posedge core_clk_in);
    endtask : sw

    task automatic prot(input logic [5:0] exp);
        repeat (10) @(posedge core_clk_in);
        bus(0, 8'h2c, 32'h0);
        chk(q, 32'(exp));
    endtask : prot

    function automatic logic [15:0] model_ext(input bit f, input bit bp);
        int hi = 15, lo = 15, hv = 0, lv = 0, v, n;
        for (n = 0; n < 14; n++) begin
            v = f ? int'(filt[n*16 +: 16]) : int'(arith[n*16 +: 16]);
            if (bp && v > 32767) v -= 65536;
            if (en[n] && pol[n] == bp) begin
                if (hi == 15 || v > hv) begin hi = n + 1; hv = v; end
                if (lo == 15 || v < lv) begin lo = n + 1; lv = v; end
            end
        end
        return 16'((hi << 8) | lo);
    endfunction : model_ext

    initial begin
        i = $urandom(31);
        repeat (5) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        for (i = 0; i < 4; i++) begin
            bus(1, 8'h28 + 8'(i * 4), 32'hffff);
            bus(0, 8'h28 + 8'(i * 4), 32'h0);
            chk(q, 32'h0);
        end
        // Ties, signed and unsigned sets, empty set, last one non-scan
        for (i = 0; i < 10; i++) begin
            en = 14'($urandom);
            pol = (i == 3) ? 14'h0 : 14'($urandom);
            for (int n = 0; n < 14; n++) begin
                arith[n*16 +: 16] <= 16'($urandom & 32'h8003);
                filt[n*16 +: 16] <= 16'($urandom & 32'h8003);
            end
            bus(1, 8'h40, 32'(i % 4));
            bus(1, 8'h44, 32'(en));
            bus(1, 8'h48, 32'(pol));
            acq(i != 9);
            if (i != 9) ext = model_ext(i[0], i[1]);
            bus(0, 8'h28, 32'h0);
            chk(q, 32'(ext));
        end
        bus(1, 8'h4c, 32'h3f);
        sw(6'h00);
        over <= 6'h04;
        prot(6'h04);
        sw(6'h04);
        bus(1, 8'h4c, 32'h3f);
        prot(6'h04);
        over <= 6'h00;
        // Let the synchroniser settle before the retry
        repeat (10) @(posedge core_clk_in);
        bus(1, 8'h4c, 32'h3f);
        prot(6'h00);
        sw(6'h00);
        over <= 6'h20;
        prot(6'h20);
        bus(1, 8'h4c, 32'h1f);
        prot(6'h00);
        sw(6'h20);
        bus(1, 8'h50, 32'h3b);
        for (i = 0; i < 3; i++) begin
            cold_cmp <= (i == 2) ? 6'h00 : 6'($urandom);
            acq(0);
            bus(0, 8'h30, 32'h0);
            chk(q, 32'(cold_cmp & 6'h1b));
        end
        finish_test();
    end
endmodule : cell_extreme_aux_fault_status_tb_top
